/* File: logic/rsbo_ctrl.sv */
// rsbo_ctrl: reset source gathering, cold-start flag and brown-out detector control
// assumes analog comparators deliver levels synchronous to sys_clk; other sources are pulses or levels
//
// Notes on behaviour
// - five sources (power-on, pin, software, watchdog, brown-out) each enter reset.
// - registers take reset values on any reset; the cold-start flag, event flag and interrupt status are reloaded only on srst.
// - processor held in power-on reset while supply is below threshold.
// - after supply good, oscillator start wait, then fetch from address zero.
// - cold-start flag set to one at end of power-on reset.
// - other resets leave the cold-start flag unchanged.
// - port 1 bits 6,7,0,1 forced quasi-bidirectional during reset.
// - threshold crossing with brown-out reset enable set resets the processor.
// - detect enable loaded with inverse of config byte two bit 7 each reset.
// - detector runs only while its enable bit is one.
// - level select loaded from inverted config bit; 0 is 2.7V, 1 is 3.8V.
// - with reset enable clear, a crossing raises the event flag and interrupt status bit 0 but no reset.
// - supply monitor writes need the timed-access unlock just before.
// - crossing sets event flag; interrupt when both enables set; software clears.
`timescale 1ns/100ps
module rsbo_ctrl #(
  parameter int HOLD_CYC = rsbo_pkg::RST_HOLD_CYC,
  parameter int OSC_CYC  = rsbo_pkg::OSC_START_CYC
) (
  input  wire logic                 sys_clk,
  input  wire logic                 srst,
  input  wire logic                 supplyAbovePor,
  input  wire logic                 supplyAboveBod,
  input  wire logic [7:0]           config_byte_two,
  input  wire rsbo_pkg::rsbo_src_t  srcIn,
  input  wire rsbo_pkg::rsbo_bus_t  bus,
  input  wire logic                 global_irq_enable,
  input  wire logic                 brownout_irq_enable,
  output logic [7:0]                rdata,
  output logic                      coreRst,
  output logic [7:0]                fetchAddr,
  output logic                      fetchStart,
  output logic [3:0]                port1ForceQuasi,
  output logic                      bodIrq,
  output logic                      irq,
  output logic                      oscEnable,
  output logic [1:0]                brownout_threshold_sel
);
  import rsbo_pkg::*;

  // ==========================================================
  // parameter checks
  // the counters are eight bits wide, and a zero count would still wait one cycle, the same as a count of one
  initial begin
    if (HOLD_CYC < 1 || HOLD_CYC > 255) begin
      $error("rsbo_ctrl: hold count must be 1..255");
    end
    if (OSC_CYC < 1 || OSC_CYC > 255) begin
      $error("rsbo_ctrl: oscillator count must be 1..255");
    end
  end

  // ==========================================================
  // state
  typedef struct packed {
    rsbo_state_t st;
    logic [7:0]  cnt;
    logic        cold;
    logic [7:0]  pwrCtrl;
    logic        brownout_detect_enable;
    logic        bodLvl;
    logic        bodRstEn;
    logic        bodFlag;
    logic        bodPrev;
    logic [1:0]  taStep;
    logic [1:0]  irqStat;
    logic [1:0]  irqMask;
    logic [7:0]  rdata;
    logic        fetch;
  } rsbo_regs_t;

  rsbo_regs_t r_r;
  rsbo_regs_t r_nxt;

  // ==========================================================
  // reset image
  // supply history starts high like the idle comparator, so reset makes no false crossing
  localparam rsbo_regs_t REGS_RST = '{
    st:       ST_POR,
    cnt:      8'h00,
    cold:     1'b0,
    pwrCtrl:  PWR_CTRL_RST,
    brownout_detect_enable:    1'b0,
    bodLvl:   1'b0,
    bodRstEn: 1'b0,
    bodFlag:  1'b0,
    bodPrev:  1'b1,
    taStep:   2'd0,
    irqStat:  2'b00,
    irqMask:  2'b00,
    rdata:    8'h00,
    fetch:    1'b0
  };

  function automatic logic isAddr(input rsbo_bus_t b, input logic [7:0] a);
    return b.addr == a;
  endfunction

  // read decode; unmapped addresses read as zero
  function automatic logic [7:0] readMux(input rsbo_regs_t s, input logic [7:0] a);
    logic [7:0] d;
    d = 8'h00;
    case (a)
      PWR_CTRL_ADDR: begin
        d           = s.pwrCtrl;
        d[COLD_BIT] = s.cold;
      end
      SUP_MON_ADDR: begin
        d[BOD_EN_BIT]   = s.brownout_detect_enable;
        d[BOD_LVL_BIT]  = s.bodLvl;
        d[BOD_RST_BIT]  = s.bodRstEn;
        d[BOD_FLAG_BIT] = s.bodFlag;
      end
      IRQ_STAT_ADDR: begin
        d = {6'h00, s.irqStat};
      end
      IRQ_MASK_ADDR: begin
        d = {6'h00, s.irqMask};
      end
      default: begin
        d = 8'h00;
      end
    endcase
    return d;
  endfunction

  // unlock sequencer; any write at all consumes a pending unlock
  function automatic logic [1:0] nextTaStep(input rsbo_bus_t b, input logic [1:0] step);
    logic [1:0] n;
    n = step;
    if (b.wr) begin
      n = 2'd0;
      if (isAddr(b, TA_ADDR) && b.wdata == TA_KEY1) begin
        n = 2'd1;
      end else if (isAddr(b, TA_ADDR) && b.wdata == TA_KEY2 && step == 2'd1) begin
        n = 2'd2;
      end
    end
    return n;
  endfunction

  // comparator code: 01 selects 2.7V, 10 selects 3.8V, 00 powers it down
  function automatic logic [1:0] levelCode(input logic en, input logic lvl);
    logic [1:0] c;
    if (!en) begin
      c = 2'b00;
    end else if (lvl) begin
      c = 2'b10;
    end else begin
      c = 2'b01;
    end
    return c;
  endfunction

  logic anySrc;
  logic bodCross;
  logic bodEvent;
  logic taOpen;

  always_comb begin
    r_nxt      = r_r;
    r_nxt.fetch = 1'b0;
    bodCross   = r_r.brownout_detect_enable && (supplyAboveBod != r_r.bodPrev);
    bodEvent   = bodCross;
    anySrc     = srcIn.pinRst || srcIn.swRst || srcIn.wdtRst || (bodCross && r_r.bodRstEn);
    taOpen     = (r_r.taStep == 2'd2);
    r_nxt.bodPrev = supplyAboveBod;

    // ==========================================================
    // reset sequencing
    case (r_r.st)
      ST_POR: begin
        if (supplyAbovePor) begin
          r_nxt.st  = ST_OSC;
          r_nxt.cnt = 8'(OSC_CYC);
        end
      end
      ST_OSC: begin
        if (!supplyAbovePor) begin
          r_nxt.st = ST_POR;
        end else if (r_r.cnt <= 8'h01) begin
          r_nxt.st  = ST_HOLD;
          r_nxt.cnt = 8'(HOLD_CYC);
          r_nxt.cold = 1'b1;
        end else begin
          r_nxt.cnt = r_r.cnt - 8'h01;
        end
      end
      ST_HOLD: begin
        // wait for every source to release
        if (!supplyAbovePor) begin
          r_nxt.st = ST_POR;
        end else if (anySrc) begin
          r_nxt.cnt = 8'(HOLD_CYC);
        end else if (r_r.cnt <= 8'h01) begin
          r_nxt.st    = ST_RUN;
          r_nxt.fetch = 1'b1;
        end else begin
          r_nxt.cnt = r_r.cnt - 8'h01;
        end
      end
      ST_RUN: begin
        if (!supplyAbovePor) begin
          r_nxt.st = ST_POR;
        end else if (anySrc) begin
          r_nxt.st  = ST_HOLD;
          r_nxt.cnt = 8'(HOLD_CYC);
        end
      end
      default: r_nxt.st = ST_POR;
    endcase

    // ==========================================================
    // register load at reset, software access when running
    if (r_r.st != ST_RUN) begin
      r_nxt.pwrCtrl  = PWR_CTRL_RST;
      r_nxt.brownout_detect_enable    = ~config_byte_two[CFG_BOD_DIS_BIT];
      r_nxt.bodLvl   = ~config_byte_two[CFG_BOD_LVL_BIT];
      r_nxt.bodRstEn = config_byte_two[CFG_BOD_RST_BIT];
      r_nxt.taStep   = 2'd0;
      r_nxt.irqMask  = 2'b00;
      r_nxt.rdata    = 8'h00;
    end else begin
      r_nxt.rdata  = 8'h00;
      r_nxt.taStep = nextTaStep(bus, r_r.taStep);
      if (bus.rd) begin
        r_nxt.rdata = readMux(r_r, bus.addr);
        if (isAddr(bus, IRQ_STAT_ADDR)) begin
          // read clears the sticky status
          r_nxt.irqStat = 2'b00;
        end
      end
      if (bus.wr) begin
        if (isAddr(bus, PWR_CTRL_ADDR)) begin
          r_nxt.pwrCtrl = bus.wdata & PWR_CTRL_WMASK;
          r_nxt.cold    = bus.wdata[COLD_BIT];
        end else if (isAddr(bus, SUP_MON_ADDR) && taOpen) begin
          r_nxt.brownout_detect_enable    = bus.wdata[BOD_EN_BIT];
          r_nxt.bodLvl   = bus.wdata[BOD_LVL_BIT];
          r_nxt.bodRstEn = bus.wdata[BOD_RST_BIT];
          r_nxt.bodFlag  = bus.wdata[BOD_FLAG_BIT];
        end else if (isAddr(bus, IRQ_MASK_ADDR)) begin
          r_nxt.irqMask = bus.wdata[1:0];
        end
      end
    end

    // ==========================================================
    // sticky events, set wins over clear
    // flag raised whether or not reset follows
    if (bodEvent) begin
      r_nxt.bodFlag    = 1'b1;
      r_nxt.irqStat[0] = 1'b1;
    end
    if (r_nxt.fetch) begin
      r_nxt.irqStat[1] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      r_r <= REGS_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign rdata      = r_r.rdata;
  assign coreRst    = (r_r.st != ST_RUN);
  assign fetchAddr  = RESET_VECTOR;
  assign fetchStart = r_r.fetch;
  for (genvar i = 0; i < 4; i++) begin : g_quasi
    assign port1ForceQuasi[i] = coreRst;
  end
  assign bodIrq     = r_r.bodFlag && brownout_irq_enable && global_irq_enable;
  assign irq        = |(r_r.irqStat & r_r.irqMask);
  assign oscEnable  = (r_r.st != ST_POR);
  assign brownout_threshold_sel = levelCode(r_r.brownout_detect_enable, r_r.bodLvl);

endmodule

/* File: logic/rsbo_pkg.sv */
// rsbo_pkg: constants and types for the reset source and brown-out control block
// assumes a single 100 MHz system clock and a byte-wide special function register port
package rsbo_pkg;

  // ==========================================================
  // register map and bit positions
  localparam logic [7:0] PWR_CTRL_ADDR   = 8'h87;
  localparam logic [7:0] SUP_MON_ADDR    = 8'hA3;
  localparam logic [7:0] IRQ_STAT_ADDR   = 8'hA4;
  localparam logic [7:0] IRQ_MASK_ADDR   = 8'hA5;
  localparam logic [7:0] TA_ADDR         = 8'hC7;
  localparam logic [7:0] TA_KEY1         = 8'hAA;
  localparam logic [7:0] TA_KEY2         = 8'h55;
  localparam int         COLD_BIT        = 4;
  localparam int         BOD_EN_BIT      = 7;
  localparam int         BOD_LVL_BIT     = 6;
  localparam int         BOD_RST_BIT     = 4;
  localparam int         BOD_FLAG_BIT    = 3;
  localparam int         CFG_BOD_DIS_BIT = 7;
  localparam int         CFG_BOD_LVL_BIT = 6;
  localparam int         CFG_BOD_RST_BIT = 4;
  localparam logic [7:0] PWR_CTRL_RST    = 8'h00;
  localparam logic [7:0] PWR_CTRL_WMASK  = 8'hDF;
  localparam logic [7:0] SUP_MON_RMASK   = 8'hD8;
  localparam logic [7:0] RESET_VECTOR    = 8'h00;

  // ==========================================================
  // timing
  localparam int CLK_MHZ        = 100;
  localparam int RST_HOLD_NS    = 100;
  localparam int RST_HOLD_CYC   = (RST_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int OSC_START_NS   = 200;
  localparam int OSC_START_CYC  = (OSC_START_NS * CLK_MHZ + 999) / 1000;

  // ==========================================================
  // types
  typedef enum logic [3:0] {
    ST_POR   = 4'h1,
    ST_OSC   = 4'h2,
    ST_HOLD  = 4'h4,
    ST_RUN   = 4'h8
  } rsbo_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rsbo_bus_t;

  typedef struct packed {
    logic pinRst;
    logic swRst;
    logic wdtRst;
  } rsbo_src_t;

endpackage

/* File: dv/rsbo_ctrl_sva.sv */
// rsbo_ctrl_sva: port checker for rsbo_ctrl
// assumes one clock domain and the sync reset srst
`timescale 1ns/100ps
module rsbo_ctrl_sva #(
  parameter int HOLD_CYC = rsbo_pkg::RST_HOLD_CYC,
  parameter int OSC_CYC  = rsbo_pkg::OSC_START_CYC
) (
  input wire logic                sys_clk,
  input wire logic                srst,
  input wire logic                supplyAbovePor,
  input wire rsbo_pkg::rsbo_src_t srcIn,
  input wire rsbo_pkg::rsbo_bus_t bus,
  input wire logic                global_irq_enable,
  input wire logic                brownout_irq_enable,
  input wire logic [7:0]          rdata,
  input wire logic                coreRst,
  input wire logic [7:0]          fetchAddr,
  input wire logic                fetchStart,
  input wire logic [3:0]          port1ForceQuasi,
  input wire logic                bodIrq,
  input wire logic                irq,
  input wire logic                oscEnable
);
  import rsbo_pkg::*;
  // ==========================================
  // checks; slack of 4 covers registered decode
  localparam int BOOT_MAX = OSC_CYC + HOLD_CYC + 4;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence bootWait;
    coreRst ##[1:BOOT_MAX] fetchStart;
  endsequence
  fetch_addr_a: assert property (fetchAddr == 8'h00) else $error("fetch address not zero");
  quasi_force_a: assert property (port1ForceQuasi == {4{coreRst}}) else $error("port force wrong");
  boot_seq_a: assert property ($rose(oscEnable) |-> bootWait) else $error("no fetch after start");
  fetch_pulse_a: assert property (fetchStart |-> $fell(coreRst) ##1 !fetchStart) else $error("bad fetch");
  por_hold_a: assert property (!supplyAbovePor && !oscEnable |=> !oscEnable && coreRst) else $error("por");
  src_hold_a: assert property (srcIn != '0 |=> coreRst) else $error("source did not hold reset");
  reset_vals_a: assert property ($past(srst) |-> coreRst && !oscEnable && rdata == 8'h00 && !irq)
    else $error("reset values wrong");
  rdata_idle_a: assert property (!$past(bus.rd) |-> rdata == 8'h00) else $error("read data not idle");
  bod_irq_a: assert property (bodIrq |-> global_irq_enable && brownout_irq_enable) else $error("irq");
  irq_quiet_a: assert property (coreRst |=> !irq) else $error("interrupt during reset");
endmodule
bind rsbo_ctrl rsbo_ctrl_sva #(.HOLD_CYC(HOLD_CYC), .OSC_CYC(OSC_CYC)) u_rsbo_ctrl_sva (
  .sys_clk(sys_clk), .srst(srst), .supplyAbovePor(supplyAbovePor), .srcIn(srcIn), .bus(bus),
  .global_irq_enable(global_irq_enable), .brownout_irq_enable(brownout_irq_enable), .rdata(rdata),
  .coreRst(coreRst), .fetchAddr(fetchAddr), .fetchStart(fetchStart), .port1ForceQuasi(port1ForceQuasi),
  .bodIrq(bodIrq), .irq(irq), .oscEnable(oscEnable));

/* File: dv/rsbo_ctrl_test.sv */
// rsbo_ctrl_test: self-checking bench for rsbo_ctrl
// assumes the checker binds itself from its own file
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module rsbo_ctrl_test;
  import rsbo_pkg::*;
  logic       sys_clk, srst, supplyAbovePor, supplyAboveBod, gIrqEn, bIrqEn;
  logic       coreRst, fetchStart, bodIrq, irq, oscEnable;
  logic [7:0] cfg, rdata, fetchAddr, v;
  logic [3:0] quasi;
  logic [1:0] sel;
  rsbo_src_t  src;
  rsbo_bus_t  bus;
  int         failures = 0, n_checks = 0, cyc = 0;
  rsbo_ctrl u_rsbo_ctrl (.sys_clk(sys_clk), .srst(srst), .supplyAbovePor(supplyAbovePor),
    .supplyAboveBod(supplyAboveBod), .config_byte_two(cfg), .srcIn(src), .bus(bus),
    .global_irq_enable(gIrqEn), .brownout_irq_enable(bIrqEn), .rdata(rdata), .coreRst(coreRst),
    .fetchAddr(fetchAddr), .fetchStart(fetchStart), .port1ForceQuasi(quasi), .bodIrq(bodIrq),
    .irq(irq), .oscEnable(oscEnable), .brownout_threshold_sel(sel));
  // ==========================================
  // clock, timeout, verdict
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // run needs well under 2000 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic [7:0] expMon(input logic [7:0] c);
    return {~c[7], ~c[6], 1'b0, c[4], 4'h0};
  endfunction
  function automatic logic [1:0] expSel(input logic [7:0] c);
    return c[7] ? 2'b00 : (c[6] ? 2'b01 : 2'b10);
  endfunction
  task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1 `CHK(rdata & m, e)
  endtask
  task automatic waitCore(input logic lvl);
    for (int i = 0; i < 300 && coreRst !== lvl; i++) @(posedge sys_clk);
    #1 `CHK(coreRst, lvl)
  endtask
  // supply monitor writes only land right after the unlock keys
  task automatic taWrite(input logic [7:0] d);
    wrReg(TA_ADDR, TA_KEY1);
    wrReg(TA_ADDR, TA_KEY2);
    wrReg(SUP_MON_ADDR, d);
  endtask
  task automatic boot(input logic [7:0] c);
    @(posedge sys_clk);
    srst <= 1'b1;
    supplyAbovePor <= 1'b0;
    cfg <= c;
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (6) @(posedge sys_clk);
    #1 `CHK({coreRst, oscEnable}, 2'b10)
    `CHK(quasi, 4'hF)
    `CHK(fetchAddr, 8'h00)
    @(posedge sys_clk);
    supplyAbovePor <= 1'b1;
    waitCore(1'b0);
    rdChk(PWR_CTRL_ADDR, 8'hFF, 8'h10);
    rdChk(SUP_MON_ADDR, 8'hF0, expMon(c));
    `CHK(sel, expSel(c))
  endtask
  // ==========================================
  // scenarios
  initial begin
    srst = 1'b1;
    supplyAbovePor = 1'b0;
    supplyAboveBod = 1'b1;
    gIrqEn = 1'b0;
    bIrqEn = 1'b0;
    src = '0;
    bus = '0;
    cfg = 8'hFF;
    void'($urandom(73578));
    boot(8'($urandom()) & 8'h6F);
    rdChk(8'h00, 8'hFF, 8'h00);
    v = 8'($urandom());
    wrReg(PWR_CTRL_ADDR, v);
    rdChk(PWR_CTRL_ADDR, 8'hFF, v & PWR_CTRL_WMASK);
    for (int s = 0; s < 3; s++) begin
      wrReg(PWR_CTRL_ADDR, (s == 1) ? 8'h1F : 8'h0F);
      @(posedge sys_clk);
      src <= rsbo_src_t'(3'(1 << s));
      @(posedge sys_clk);
      src <= '0;
      #1 `CHK(coreRst, 1'b1)
      waitCore(1'b0);
      rdChk(PWR_CTRL_ADDR, 8'hFF, (s == 1) ? 8'h10 : 8'h00);
    end
    wrReg(IRQ_MASK_ADDR, 8'h02);
    #1 `CHK(irq, 1'b1)
    rdChk(IRQ_STAT_ADDR, 8'hFF, 8'h02);
    `CHK(irq, 1'b0)
    wrReg(TA_ADDR, TA_KEY1);
    wrReg(TA_ADDR, TA_KEY2);
    wrReg(PWR_CTRL_ADDR, 8'h00);
    wrReg(SUP_MON_ADDR, 8'h00);
    rdChk(SUP_MON_ADDR, 8'hF0, expMon(cfg));
    taWrite(8'h80);
    rdChk(SUP_MON_ADDR, 8'hD8, 8'h80);
    `CHK(sel, 2'b01)
    wrReg(IRQ_MASK_ADDR, 8'h01);
    gIrqEn <= 1'b1;
    bIrqEn <= 1'b1;
    supplyAboveBod <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 `CHK({coreRst, bodIrq, irq}, 3'b011)
    rdChk(SUP_MON_ADDR, 8'hD8, 8'h88);
    @(posedge sys_clk);
    gIrqEn <= 1'b0;
    rdChk(IRQ_STAT_ADDR, 8'h01, 8'h01);
    `CHK({bodIrq, irq}, 2'b00)
    taWrite(8'h90);
    supplyAboveBod <= 1'b1;
    waitCore(1'b1);
    waitCore(1'b0);
    rdChk(SUP_MON_ADDR, 8'hD8, expMon(cfg) | 8'h08);
    taWrite(8'h10);
    supplyAboveBod <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 `CHK(coreRst, 1'b0)
    rdChk(SUP_MON_ADDR, 8'hD8, 8'h10);
    `CHK(sel, 2'b00)
    boot(8'hFF);
    print_verdict();
  end
endmodule
